// >>> common/dtm_pkg.sv
/*
  Constants, register offsets and the timer mode type shared by the dual
  counter/timer block. Assumes an 8-bit special function register bus.
*/
`default_nettype none
package dtm_pkg;
  // register offsets on the special function register bus
  localparam logic [7:0] DTM_ADDR_CTRL    = 8'h88;
  localparam logic [7:0] DTM_ADDR_MODE    = 8'h89;
  localparam logic [7:0] DTM_ADDR_TMR0_LO = 8'h8A;
  localparam logic [7:0] DTM_ADDR_TMR1_LO = 8'h8B;
  localparam logic [7:0] DTM_ADDR_TMR0_HI = 8'h8C;
  localparam logic [7:0] DTM_ADDR_TMR1_HI = 8'h8D;

  localparam logic [7:0] DTM_CTRL_RST  = 8'h00;
  localparam logic [7:0] DTM_MODE_RST  = 8'h00;
  localparam logic [7:0] DTM_CNT_RST   = 8'h00;
  localparam logic [7:0] DTM_UNMAPPED  = 8'h00;
  localparam logic [7:0] DTM_BYTE_ONES = 8'hFF;
  localparam logic [7:0] DTM_BYTE_ONE  = 8'h01;
  localparam logic [4:0] DTM_LOW5_ONES = 5'h1F;
  localparam logic [12:0] DTM_CNT13_ONE = 13'h0001;
  localparam logic [15:0] DTM_CNT16_ONE = 16'h0001;

  // control/status register bit positions
  localparam int DTM_CTL_OVF_1  = 7;
  localparam int DTM_CTL_RUN_1  = 6;
  localparam int DTM_CTL_OVF_0  = 5;
  localparam int DTM_CTL_RUN_0  = 4;
  localparam int DTM_CTL_EXF_1  = 3;
  localparam int DTM_CTL_EXTY_1 = 2;
  localparam int DTM_CTL_EXF_0  = 1;
  localparam int DTM_CTL_EXTY_0 = 0;

  // mode register bit positions
  localparam int DTM_MD_GATE_1  = 7;
  localparam int DTM_MD_CSEL_1  = 6;
  localparam int DTM_MD_MODE_1  = 4;
  localparam int DTM_MD_GATE_0  = 3;
  localparam int DTM_MD_CSEL_0  = 2;
  localparam int DTM_MD_MODE_0  = 0;

  typedef enum logic [1:0] {
    DTM_MODE_13BIT  = 2'b00,
    DTM_MODE_16BIT  = 2'b01,
    DTM_MODE_RELOAD = 2'b10,
    DTM_MODE_SPLIT  = 2'b11
  } dtm_mode_t;
endpackage
`default_nettype wire

// >>> design/dtm_count_source.sv
/*
  Count-enable unit for one timer: picks the timebase and applies run and
  gating. Assumes the pin and gate inputs are synchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dtm_count_source
  import dtm_pkg::*;
(
  input  wire logic core_clk,      // system clock
  input  wire logic rst,           // async reset, active high
  input  wire logic run,           // run control
  input  wire logic gate_en,       // external gating enabled
  input  wire logic gate_active,   // external gate input active
  input  wire logic count_sel,     // 1: count pin falling edges
  input  wire logic clock_sel,     // 1: system clock, 0: prescaled
  input  wire logic prescale_tick, // prescaled clock enable
  input  wire logic count_pin,     // external count input
  output logic      count_pulse    // one increment this cycle
);
  logic pin_prev_reg;
  wire  enabled  = run & (~gate_en | gate_active);        // [R6]
  wire  fall     = pin_prev_reg & ~count_pin;              // [R18]
  wire  timebase = count_sel ? fall : (clock_sel | prescale_tick); // [R19]

  assign count_pulse = enabled & timebase;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pin_prev_reg <= 1'b0;
    else
      pin_prev_reg <= count_pin;
  end

  property p_fall_counts;
    @(posedge core_clk) disable iff (rst)
      (run && !gate_en && count_sel && pin_prev_reg && !count_pin) |-> count_pulse;
  endproperty
  a_fall_counts: assert property (p_fall_counts) // [R18]
    else $error("falling edge on count pin did not count");
endmodule
`default_nettype wire

// >>> design/dtm_timers.sv
/*
  Two counter/timers in modes 0 to 3 with the control/status register,
  reached over the special function register bus. Assumes the core issues
  single-cycle byte or bit writes and that vector acks are one-cycle pulses.
*/
// Notes on behaviour
// (R1) mode 1 counts the full 16-bit high:low register, enabled as mode 0.
// (R2) mode 2 counts the low byte; high byte holds the reload value.
// (R3) low byte rolling over from all ones sets overflow flag and reloads.
// (R4) reloading never modifies the high byte reload value.
// (R5) software loads the low byte before enabling an auto-reload timer.
// (R6) timer counts only with run set and gate clear or gate input active; in split mode timer 1 ignores its run and gate bits.
// (R7) timer 1 auto-reload behaves like timer 0 with its own bits.
// (R8) split mode: timer 0 low byte is a counter under timer 0 controls.
// (R9) split low byte counts system/prescaled clock or pin per count-select.
// (R10) split high byte is a timer only, run by timer 1 run bit.
// (R11) split high byte overflow sets timer 1 overflow flag.
// (R12) in split mode timer 1 counts no pins and sets no flag.
// (R13) timer 1 overflow still reaches baud and conversion trigger output.
// (R14) in split mode timer 1 runs in modes 0..2, stops in mode 3.
// (R15) overflow flags set by hardware, cleared by software or on vectoring.
// (R16) type bit: 0 level follows input, 1 edge sets flag, vector clears.
// (R17) control register resets to zero and is bit writable.
// (R18) counter mode increments on each sampled falling edge of the pin.
// (R19) timer mode uses system clock if clock-select set, else prescaled.
// (R20) setting run does not clear or preload the count registers.
`timescale 1ns/1ns
`default_nettype none
module dtm_timers
  import dtm_pkg::*;
(
  input  wire logic       core_clk,                // system clock, 100 MHz
  input  wire logic       rst,                     // async reset, active high
  input  wire logic [7:0] sfr_addr,                // register address
  input  wire logic       sfr_wr_en,               // byte write strobe
  input  wire logic [7:0] sfr_wdata,               // byte write data
  input  wire logic       sfr_bit_wr_en,           // single-bit write strobe
  input  wire logic [2:0] sfr_bit_idx,             // bit number for bit write
  input  wire logic       sfr_bit_val,             // bit write value
  input  wire logic       sfr_rd_en,               // read strobe
  output logic      [7:0] sfr_rdata,               // read data, next cycle
  input  wire logic       timer_zero_count_pin,    // timer 0 count input
  input  wire logic       timer_one_count_pin,     // timer 1 count input
  input  wire logic       ext_gate_input_zero,     // external input 0
  input  wire logic       ext_gate_input_one,      // external input 1
  input  wire logic       ext_input_zero_polarity, // 1: input 0 active high
  input  wire logic       ext_input_one_polarity,  // 1: input 1 active high
  input  wire logic       timer_zero_clock_select, // 1: timer 0 on system clock
  input  wire logic       timer_one_clock_select,  // 1: timer 1 on system clock
  input  wire logic       prescale_tick,           // prescaled clock enable
  input  wire logic       timer_zero_vector_ack,   // core vectors to timer 0
  input  wire logic       timer_one_vector_ack,    // core vectors to timer 1
  input  wire logic       ext_zero_vector_ack,     // core vectors to ext 0
  input  wire logic       ext_one_vector_ack,      // core vectors to ext 1
  output logic            timer_zero_irq,          // timer 0 overflow flag
  output logic            timer_one_irq,           // timer 1 overflow flag
  output logic            ext_irq_zero,            // external flag 0
  output logic            ext_irq_one,             // external flag 1
  output logic            timer_one_overflow_tick  // timer 1 overflow pulse
);
  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] mode_reg;
  logic [7:0] tmr0_lo_reg, tmr0_lo_next, tmr0_hi_reg, tmr0_hi_next;
  logic [7:0] tmr1_lo_reg, tmr1_lo_next, tmr1_hi_reg, tmr1_hi_next;
  logic [7:0] rdata_reg;
  logic       ovf1_tick_reg;
  logic [1:0] ext_prev_reg;

  // returns {overflow, high next, low next} for one increment
  function automatic logic [16:0] dtm_step(input dtm_mode_t m, input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [12:0] c13;
    logic [15:0] c16;
    c13 = {hi, lo[4:0]} + DTM_CNT13_ONE;
    c16 = {hi, lo} + DTM_CNT16_ONE;
    unique case (m)
      DTM_MODE_13BIT:  dtm_step = {(hi == DTM_BYTE_ONES) && (lo[4:0] == DTM_LOW5_ONES),
                                   c13[12:5], lo[7:5], c13[4:0]};
      DTM_MODE_16BIT:  dtm_step = {(hi == DTM_BYTE_ONES) && (lo == DTM_BYTE_ONES),
                                   c16};                                   // [R1]
      DTM_MODE_RELOAD: dtm_step = (lo == DTM_BYTE_ONES) ? {1'b1, hi, hi}   // [R2] [R4]
                                                        : {1'b0, hi, lo + DTM_BYTE_ONE};
      DTM_MODE_SPLIT:  dtm_step = {lo == DTM_BYTE_ONES, hi, lo + DTM_BYTE_ONE}; // [R8]
    endcase
  endfunction

  // mode decode
  dtm_mode_t tmr0_mode, tmr1_mode;
  assign tmr0_mode = dtm_mode_t'(mode_reg[DTM_MD_MODE_0 +: 2]);
  assign tmr1_mode = dtm_mode_t'(mode_reg[DTM_MD_MODE_1 +: 2]);
  wire split     = (tmr0_mode == DTM_MODE_SPLIT);
  wire ext0_act  = ext_gate_input_zero ~^ ext_input_zero_polarity;
  wire ext1_act  = ext_gate_input_one ~^ ext_input_one_polarity;

  // count-source inputs per timer
  wire [1:0] src_run, src_gate, src_act, src_csel, src_ksel, src_pin, src_pulse;
  assign src_run[0]  = ctl_reg[DTM_CTL_RUN_0];                           // [R8]
  assign src_run[1]  = (tmr1_mode != DTM_MODE_SPLIT) &
                       (split | ctl_reg[DTM_CTL_RUN_1]);                 // [R14]
  assign src_gate[0] = mode_reg[DTM_MD_GATE_0];
  assign src_gate[1] = mode_reg[DTM_MD_GATE_1] & ~split;
  assign src_act     = {ext1_act, ext0_act};
  assign src_csel[0] = mode_reg[DTM_MD_CSEL_0];                          // [R9]
  assign src_csel[1] = mode_reg[DTM_MD_CSEL_1] & ~split;                 // [R12]
  assign src_ksel    = {timer_one_clock_select, timer_zero_clock_select};
  assign src_pin     = {timer_one_count_pin, timer_zero_count_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_src
      dtm_count_source u_src (
        .core_clk      (core_clk),
        .rst           (rst),
        .run           (src_run[gi]),
        .gate_en       (src_gate[gi]),
        .gate_active   (src_act[gi]),
        .count_sel     (src_csel[gi]),
        .clock_sel     (src_ksel[gi]),
        .prescale_tick (prescale_tick),
        .count_pin     (src_pin[gi]),
        .count_pulse   (src_pulse[gi])
      );
    end
  endgenerate

  // counting
  wire [16:0] step0    = dtm_step(tmr0_mode, tmr0_hi_reg, tmr0_lo_reg);
  wire [16:0] step1    = dtm_step(tmr1_mode, tmr1_hi_reg, tmr1_lo_reg);
  wire        ovf0     = src_pulse[0] & step0[16];
  wire        ovf1     = src_pulse[1] & step1[16];
  // split high byte is a plain timer: never the pin, always timer 0 clock choice
  wire        hi_tick  = split & ctl_reg[DTM_CTL_RUN_1] &
                         (timer_zero_clock_select | prescale_tick);      // [R10]
  wire        hi_ovf   = hi_tick & (tmr0_hi_reg == DTM_BYTE_ONES);
  wire [7:0]  hi_inc   = tmr0_hi_reg + DTM_BYTE_ONE;

  // bus decode
  wire wr_ctl  = sfr_wr_en & (sfr_addr == DTM_ADDR_CTRL);
  wire bit_ctl = sfr_bit_wr_en & (sfr_addr == DTM_ADDR_CTRL);
  wire wr_mode = sfr_wr_en & (sfr_addr == DTM_ADDR_MODE);
  wire wr_0lo  = sfr_wr_en & (sfr_addr == DTM_ADDR_TMR0_LO);
  wire wr_0hi  = sfr_wr_en & (sfr_addr == DTM_ADDR_TMR0_HI);
  wire wr_1lo  = sfr_wr_en & (sfr_addr == DTM_ADDR_TMR1_LO);
  wire wr_1hi  = sfr_wr_en & (sfr_addr == DTM_ADDR_TMR1_HI);
  wire [7:0] read_mux =
    (sfr_addr == DTM_ADDR_CTRL)    ? ctl_reg     :
    (sfr_addr == DTM_ADDR_MODE)    ? mode_reg    :
    (sfr_addr == DTM_ADDR_TMR0_LO) ? tmr0_lo_reg :
    (sfr_addr == DTM_ADDR_TMR0_HI) ? tmr0_hi_reg :
    (sfr_addr == DTM_ADDR_TMR1_LO) ? tmr1_lo_reg :
    (sfr_addr == DTM_ADDR_TMR1_HI) ? tmr1_hi_reg : DTM_UNMAPPED;

  // software writes win over a count in the same cycle; counts resume from
  // whatever is held, run never preloads
  always_comb
  begin
    tmr0_lo_next = wr_0lo ? sfr_wdata : (src_pulse[0] ? step0[7:0] : tmr0_lo_reg);   // [R20]
    tmr1_lo_next = wr_1lo ? sfr_wdata : (src_pulse[1] ? step1[7:0] : tmr1_lo_reg);   // [R7]
    tmr1_hi_next = wr_1hi ? sfr_wdata : (src_pulse[1] ? step1[15:8] : tmr1_hi_reg);
    if (wr_0hi)
      tmr0_hi_next = sfr_wdata;
    else if (split)
      tmr0_hi_next = hi_tick ? hi_inc : tmr0_hi_reg;
    else
      tmr0_hi_next = src_pulse[0] ? step0[15:8] : tmr0_hi_reg;
  end

  // control register: software write, then vector clears, then hardware sets
  wire edge0 = ext0_act & ~ext_prev_reg[0];
  wire edge1 = ext1_act & ~ext_prev_reg[1];
  always_comb
  begin
    ctl_next = ctl_reg;
    if (wr_ctl)
      ctl_next = sfr_wdata;
    else if (bit_ctl)
      ctl_next[sfr_bit_idx] = sfr_bit_val;                                // [R17]
    if (timer_zero_vector_ack)
      ctl_next[DTM_CTL_OVF_0] = 1'b0;
    if (timer_one_vector_ack)
      ctl_next[DTM_CTL_OVF_1] = 1'b0;
    if (ext_zero_vector_ack)
      ctl_next[DTM_CTL_EXF_0] = 1'b0;
    if (ext_one_vector_ack)
      ctl_next[DTM_CTL_EXF_1] = 1'b0;
    if (ovf0)
      ctl_next[DTM_CTL_OVF_0] = 1'b1;                                     // [R3] [R15]
    if ((ovf1 & ~split) | hi_ovf)
      ctl_next[DTM_CTL_OVF_1] = 1'b1;                                     // [R11] [R12]
    if (ctl_reg[DTM_CTL_EXTY_0])
      ctl_next[DTM_CTL_EXF_0] = ctl_next[DTM_CTL_EXF_0] | edge0;          // [R16]
    else
      ctl_next[DTM_CTL_EXF_0] = ext0_act;
    if (ctl_reg[DTM_CTL_EXTY_1])
      ctl_next[DTM_CTL_EXF_1] = ctl_next[DTM_CTL_EXF_1] | edge1;          // [R16]
    else
      ctl_next[DTM_CTL_EXF_1] = ext1_act;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_reg       <= DTM_CTRL_RST;                                      // [R17]
      mode_reg      <= DTM_MODE_RST;
      tmr0_lo_reg   <= DTM_CNT_RST;
      tmr0_hi_reg   <= DTM_CNT_RST;
      tmr1_lo_reg   <= DTM_CNT_RST;
      tmr1_hi_reg   <= DTM_CNT_RST;
      rdata_reg     <= DTM_UNMAPPED;
      ovf1_tick_reg <= 1'b0;
      ext_prev_reg  <= 2'b00;
    end
    else
    begin
      ctl_reg       <= ctl_next;
      mode_reg      <= wr_mode ? sfr_wdata : mode_reg;
      tmr0_lo_reg   <= tmr0_lo_next;
      tmr0_hi_reg   <= tmr0_hi_next;
      tmr1_lo_reg   <= tmr1_lo_next;
      tmr1_hi_reg   <= tmr1_hi_next;
      rdata_reg     <= sfr_rd_en ? read_mux : rdata_reg;
      ovf1_tick_reg <= ovf1;                                              // [R13]
      ext_prev_reg  <= {ext1_act, ext0_act};
    end
  end

  assign sfr_rdata               = rdata_reg;
  assign timer_zero_irq          = ctl_reg[DTM_CTL_OVF_0];
  assign timer_one_irq           = ctl_reg[DTM_CTL_OVF_1];
  assign ext_irq_zero            = ctl_reg[DTM_CTL_EXF_0];
  assign ext_irq_one             = ctl_reg[DTM_CTL_EXF_1];
  assign timer_one_overflow_tick = ovf1_tick_reg;

  wire no_cnt_wr = !(wr_0lo || wr_0hi || wr_1lo || wr_1hi);

  property p_reload;
    @(posedge core_clk) disable iff (rst)
      (tmr0_mode == DTM_MODE_RELOAD && src_pulse[0] && tmr0_lo_reg == DTM_BYTE_ONES
       && no_cnt_wr) |=> (tmr0_lo_reg == $past(tmr0_hi_reg)) && timer_zero_irq;
  endproperty
  a_reload: assert property (p_reload) // [R3]
    else $error("mode 2 rollover did not reload and flag");

  property p_reload_keep;
    @(posedge core_clk) disable iff (rst)
      (tmr1_mode == DTM_MODE_RELOAD && !wr_1hi) |=> $stable(tmr1_hi_reg);
  endproperty
  a_reload_keep: assert property (p_reload_keep) // [R4]
    else $error("reload value changed");

  property p_sixteen;
    @(posedge core_clk) disable iff (rst)
      (tmr0_mode == DTM_MODE_16BIT && src_pulse[0] && tmr0_lo_reg == DTM_BYTE_ONES
       && no_cnt_wr) |=> tmr0_hi_reg == $past(tmr0_hi_reg) + DTM_BYTE_ONE && tmr0_lo_reg == 8'h00;
  endproperty
  a_sixteen: assert property (p_sixteen) // [R1]
    else $error("16-bit carry into high byte missing");

  property p_gate_hold;
    @(posedge core_clk) disable iff (rst)
      (!split && (!ctl_reg[DTM_CTL_RUN_0] || (mode_reg[DTM_MD_GATE_0] && !ext0_act))
       && no_cnt_wr) |=> $stable(tmr0_lo_reg) && $stable(tmr0_hi_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold) // [R6]
    else $error("timer 0 counted while disabled");

  property p_split_flag;
    @(posedge core_clk) disable iff (rst)
      hi_ovf |=> timer_one_irq ##0 tmr0_hi_reg == 8'h00 || $past(wr_0hi);
  endproperty
  a_split_flag: assert property (p_split_flag) // [R11]
    else $error("split high byte overflow did not set timer 1 flag");

  property p_split_noflag;
    @(posedge core_clk) disable iff (rst)
      (split && !hi_ovf && !timer_one_irq && !wr_ctl && !bit_ctl) |=> !timer_one_irq;
  endproperty
  a_split_noflag: assert property (p_split_noflag) // [R12]
    else $error("timer 1 set its own flag in split mode");

  property p_tick;
    @(posedge core_clk) disable iff (rst)
      ovf1 |=> timer_one_overflow_tick ##1 !timer_one_overflow_tick || $past(ovf1);
  endproperty
  a_tick: assert property (p_tick) // [R13]
    else $error("timer 1 overflow tick missing");

  property p_t1_stop;
    @(posedge core_clk) disable iff (rst)
      (tmr1_mode == DTM_MODE_SPLIT && !wr_1lo && !wr_1hi) |=>
        $stable(tmr1_lo_reg) && $stable(tmr1_hi_reg);
  endproperty
  a_t1_stop: assert property (p_t1_stop) // [R14]
    else $error("timer 1 ran in mode 3");

  property p_set_wins;
    @(posedge core_clk) disable iff (rst)
      (ovf0 && (timer_zero_vector_ack || wr_ctl)) |=> timer_zero_irq;
  endproperty
  a_set_wins: assert property (p_set_wins) // [R15]
    else $error("overflow lost against a clear");

  property p_edge;
    @(posedge core_clk) disable iff (rst)
      (ctl_reg[DTM_CTL_EXTY_0] && edge0) |=> ext_irq_zero;
  endproperty
  a_edge: assert property (p_edge) // [R16]
    else $error("edge did not set external flag 0");
endmodule
`default_nettype wire

// >>> bench/dtm_core_model.sv
/*
  Behavioural processor core for the dual timer block: byte writes, bit
  writes and reads on the special function register bus.
  Assumes its tasks are called just after a rising edge of core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module dtm_core_model
  import dtm_pkg::*;
(
  input  wire logic       core_clk,      // system clock
  output logic      [7:0] sfr_addr,      // register address
  output logic            sfr_wr_en,     // byte write strobe
  output logic      [7:0] sfr_wdata,     // byte write data
  output logic            sfr_bit_wr_en, // bit write strobe
  output logic      [2:0] sfr_bit_idx,   // bit number
  output logic            sfr_bit_val,   // bit value
  output logic            sfr_rd_en      // read strobe
);
  initial
  begin
    sfr_addr      = DTM_UNMAPPED;
    sfr_wr_en     = 1'h0;
    sfr_wdata     = 8'h00;
    sfr_bit_wr_en = 1'h0;
    sfr_bit_idx   = 3'h0;
    sfr_bit_val   = 1'h0;
    sfr_rd_en     = 1'h0;
  end

  // each access leaves a free edge behind it, so no strobe is set twice in one step;
  // released address and data lines show the inverse, a bit write inverts only its value, so a stale value is never mistaken for live data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'h1;
    @(posedge core_clk);
    sfr_wr_en <= 1'h0;
    sfr_addr  <= ~a;
    sfr_wdata <= ~d;
    @(posedge core_clk);
  endtask

  task automatic bitwr(input logic [2:0] i, input logic v);
    sfr_addr      <= DTM_ADDR_CTRL;
    sfr_bit_idx   <= i;
    sfr_bit_val   <= v;
    sfr_bit_wr_en <= 1'h1;
    @(posedge core_clk);
    sfr_bit_wr_en <= 1'h0;
    sfr_bit_val   <= ~v;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    sfr_addr  <= a;
    sfr_rd_en <= 1'h1;
    @(posedge core_clk);
    sfr_rd_en <= 1'h0;
    sfr_addr  <= ~a;
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/dual_timer_modes_one_to_three_tb.sv
/*
  Self-checking bench for the dual counter/timer block. Reads queue their
  expected byte; a monitor compares it half a cycle after the read edge.
  Assumes the core model drives the register bus; ticks and pins come from here.
*/
`timescale 1ns/1ns
`default_nettype none
module dual_timer_modes_one_to_three_tb
  import dtm_pkg::*;
;
  logic       core_clk;
  logic       rst;
  wire  [7:0] sfr_addr;
  wire  [7:0] sfr_wdata;
  wire  [7:0] sfr_rdata;
  wire  [2:0] sfr_bit_idx;
  wire        sfr_wr_en;
  wire        sfr_bit_wr_en;
  wire        sfr_bit_val;
  wire        sfr_rd_en;
  wire        t0_irq;
  wire        t1_irq;
  wire        e0_irq;
  wire        e1_irq;
  wire        ovf_tick;
  logic [1:0] pin;
  logic [1:0] ext_in;
  logic [3:0] acks;
  logic       tick_en;
  logic [1:0] pol;
  logic [1:0] ksel;
  logic       rd_taken;
  logic [7:0] exp_q[$];
  int         errors;
  int         tests_run;
  int         ovf_count;

  dtm_core_model dtm_core_model_inst (.core_clk(core_clk), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata), .sfr_bit_wr_en(sfr_bit_wr_en),
    .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .sfr_rd_en(sfr_rd_en));

  dtm_timers dtm_timers_inst (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata), .sfr_bit_wr_en(sfr_bit_wr_en),
    .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .sfr_rd_en(sfr_rd_en),
    .sfr_rdata(sfr_rdata), .timer_zero_count_pin(pin[0]), .timer_one_count_pin(pin[1]),
    .ext_gate_input_zero(ext_in[0]), .ext_gate_input_one(ext_in[1]),
    .ext_input_zero_polarity(pol[0]), .ext_input_one_polarity(pol[1]),
    .timer_zero_clock_select(ksel[0]), .timer_one_clock_select(ksel[1]),
    .prescale_tick(tick_en), .timer_zero_vector_ack(acks[0]),
    .timer_one_vector_ack(acks[1]), .ext_zero_vector_ack(acks[2]),
    .ext_one_vector_ack(acks[3]), .timer_zero_irq(t0_irq), .timer_one_irq(t1_irq),
    .ext_irq_zero(e0_irq), .ext_irq_one(e1_irq), .timer_one_overflow_tick(ovf_tick));

  initial core_clk = 1'h0;
  always #5 core_clk = ~core_clk;

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge core_clk) rd_taken <= sfr_rd_en;

  // read data stands from the edge after the read, so look half a cycle later
  always @(negedge core_clk)
  begin
    if (ovf_tick === 1'h1)
      ovf_count++;
    if (rd_taken === 1'h1)
    begin
      if (exp_q.size() == 0)
        check("unexpected_read", 8'h00, 8'hFF);
      else
        check("sfr_rdata", exp_q.pop_front(), sfr_rdata);
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    dtm_core_model_inst.wr(a, d);
  endtask
  task automatic bitwr(input logic [2:0] i, input logic v);
    dtm_core_model_inst.bitwr(i, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    dtm_core_model_inst.rd(a);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      tick_en <= 1'h1;
      @(posedge core_clk);
      tick_en <= 1'h0;
      @(posedge core_clk);
    end
  endtask
  task automatic ack(input int i);
    acks[i] <= 1'h1;
    @(posedge core_clk);
    acks[i] <= 1'h0;
    @(posedge core_clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    complete_run();
  end

  initial
  begin
    logic [7:0] th;
    logic [7:0] lo;
    logic [7:0] hi;
    rst = 1'h1;
    pin = 2'h3;
    ext_in = 2'h0;
    acks = 4'h0;
    tick_en = 1'h0;
    pol = 2'h3;
    ksel = 2'h0;
    errors = 0;
    tests_run = 0;
    ovf_count = 0;
    void'($urandom(32'hEE8A));
    idle(6);
    rst <= 1'h0;
    idle(1);
    for (int a = 8'h88; a <= 8'h8E; a++)
      rd(a[7:0], DTM_CNT_RST);
    for (int i = 0; i < 8; i += 2)
    begin
      bitwr(i[2:0], 1'h1);
      rd(DTM_ADDR_CTRL, 8'h55 >> (6 - i));
    end
    wr(DTM_ADDR_CTRL, 8'h00);
    // same auto-reload walk for both timers, gate held off at first
    for (int t = 0; t < 2; t++)
    begin
      lo = t ? DTM_ADDR_TMR1_LO : DTM_ADDR_TMR0_LO;
      hi = t ? DTM_ADDR_TMR1_HI : DTM_ADDR_TMR0_HI;
      th = 8'($urandom % 240);
      wr(DTM_ADDR_MODE, t ? 8'hA0 : 8'h0A);
      wr(hi, th);
      wr(lo, 8'hFE);
      bitwr(t ? 3'h6 : 3'h4, 1'h1);
      tick(3);
      ext_in[t] <= 1'h1;
      tick(3);
      check("ext_irq_level", 8'h01, {7'h00, t ? e1_irq : e0_irq});
      ext_in[t] <= 1'h0;
      bitwr(t ? 3'h6 : 3'h4, 1'h0);
      rd(lo, th + 8'h01);
      rd(hi, th);
      rd(DTM_ADDR_CTRL, t ? 8'h80 : 8'h20);
      check("timer_irq", 8'h01, {7'h00, t ? t1_irq : t0_irq});
      ack(t);
      rd(DTM_ADDR_CTRL, 8'h00);
    end
    wr(DTM_ADDR_MODE, 8'h01);
    wr(DTM_ADDR_TMR0_HI, 8'hFF);
    wr(DTM_ADDR_TMR0_LO, 8'hFE);
    bitwr(3'h4, 1'h1);
    tick(3);
    wr(DTM_ADDR_MODE, 8'h05);
    repeat (2)
    begin
      pin[0] <= 1'h0;
      idle(2);
      pin[0] <= 1'h1;
      idle(2);
    end
    bitwr(3'h4, 1'h0);
    rd(DTM_ADDR_TMR0_LO, 8'h03);
    rd(DTM_ADDR_TMR0_HI, 8'h00);
    rd(DTM_ADDR_CTRL, 8'h20);
    bitwr(3'h5, 1'h0);
    rd(DTM_ADDR_CTRL, 8'h00);
    wr(DTM_ADDR_MODE, 8'h13);
    wr(DTM_ADDR_TMR0_LO, 8'hFF);
    wr(DTM_ADDR_TMR0_HI, 8'hFE);
    wr(DTM_ADDR_TMR1_LO, 8'hFF);
    wr(DTM_ADDR_TMR1_HI, 8'hFF);
    ovf_count = 0;
    wr(DTM_ADDR_CTRL, 8'h50);
    tick(1);
    rd(DTM_ADDR_CTRL, 8'h70);
    tick(1);
    wr(DTM_ADDR_MODE, 8'h33);
    tick(2);
    rd(DTM_ADDR_CTRL, 8'hF0);
    wr(DTM_ADDR_CTRL, 8'hA0);
    rd(DTM_ADDR_TMR0_LO, 8'h03);
    rd(DTM_ADDR_TMR0_HI, 8'h02);
    rd(DTM_ADDR_TMR1_LO, 8'h01);
    rd(DTM_ADDR_TMR1_HI, 8'h00);
    rd(DTM_ADDR_CTRL, 8'hA0);
    check("ovf_tick_count", 8'h01, 8'(ovf_count));
    wr(DTM_ADDR_CTRL, 8'h00);
    bitwr(3'h0, 1'h1);
    ext_in[0] <= 1'h1;
    idle(3);
    ext_in[0] <= 1'h0;
    idle(3);
    check("ext_irq_zero", 8'h01, {7'h00, e0_irq});
    rd(DTM_ADDR_CTRL, 8'h03);
    ack(2);
    rd(DTM_ADDR_CTRL, 8'h01);
    // active-low gate input and system clock: five counts in 13-bit mode,
    // and the polarity flip itself is an active edge for the edge-mode flag
    pol[0] <= 1'h0;
    ksel[0] <= 1'h1;
    wr(DTM_ADDR_MODE, 8'h08);
    wr(DTM_ADDR_TMR0_LO, 8'hFE);
    wr(DTM_ADDR_TMR0_HI, 8'h12);
    bitwr(3'h4, 1'h1);
    idle(3);
    bitwr(3'h4, 1'h0);
    rd(DTM_ADDR_TMR0_LO, 8'hE3);
    rd(DTM_ADDR_TMR0_HI, 8'h13);
    rd(DTM_ADDR_CTRL, 8'h03);
    // the vector ack lands in the very cycle of the 16-bit overflow
    wr(DTM_ADDR_MODE, 8'h01);
    wr(DTM_ADDR_TMR0_HI, 8'hFF);
    wr(DTM_ADDR_TMR0_LO, 8'hFE);
    bitwr(3'h4, 1'h1);
    ack(0);
    bitwr(3'h4, 1'h0);
    rd(DTM_ADDR_TMR0_LO, 8'h02);
    rd(DTM_ADDR_CTRL, 8'h23);
    idle(2);
    complete_run();
  end
endmodule
`default_nettype wire
